// [rtl/mcu_bus_pin_interface.sv]
// Host bus pin block: address latch, read drive, strobes, reset, port pin muxing
// Summary of operation
// [R1] Muxed host: low address shares data lanes
// [R2] Plain host: A0-7 lower, A8-15 upper
// [R3] Burst host: A4-A19 share both data lanes
// [R4] Capture address on latch or strobe input
// [R5] Drive read data only when read and selected
// [R6] Forward both port addresses to logic arrays
// [R7] Control zero: write, direction or low write
// [R8] Control one: read, E, strobe, low strobe
// [R9] Control two: five byte or fetch modes
// [R10] All control inputs feed the logic arrays
// [R11] Reset clears ports, macrocells, configuration
// [R12] Host holds reset low at power-up
// [R13] Reset aborts running flash program or erase
// [R14] Port D bit0: latch, strobe or logic input
// [R15] Port D bit1 clock drives macrocells, counter
// [R16] Chip select low enables memories and I/O
// [R17] Chip select edge leaves power-down mode
// [R18] Port D bit3 as high byte write strobe
// [R19] Ports A/B: host I/O, logic out or in
// [R20] Port C: host I/O, chip select out, input
// [R21] Port E bit0: host I/O, address or TMS
// [R22] Latched address holds until next latch strobe
module mcu_bus_pin_interface (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Configuration
  input wire logic i_bus_muxed,
  input wire mcu_pins_pkg::ctl0_mode_type i_ctl0_mode,
  input wire mcu_pins_pkg::ctl1_mode_type i_ctl1_mode,
  input wire mcu_pins_pkg::ctl2_mode_type i_ctl2_mode,
  input wire mcu_pins_pkg::pd0_mode_type i_pd0_mode,
  input wire logic i_pd1_clock_in_sel,
  input wire logic i_pd2_chip_sel_en,
  input wire logic i_pd3_write_high_en,
  input wire logic [15:0] i_port_a_mode,
  input wire logic [15:0] i_port_b_mode,
  input wire logic [15:0] i_port_c_mode,
  input wire mcu_pins_pkg::pe0_mode_type i_pe0_mode,
  // Address/data pins
  input wire logic [7:0] i_lower_addr_data_port,
  output logic [7:0] o_lower_addr_data_port,
  output logic o_lower_addr_data_oe,
  input wire logic [7:0] i_upper_addr_data_port,
  output logic [7:0] o_upper_addr_data_port,
  output logic o_upper_addr_data_oe,
  // Host control and port D pins
  input wire logic i_host_control_in_zero,
  input wire logic i_host_control_in_one,
  input wire logic i_host_control_in_two,
  input wire logic i_port_d_bit0,
  input wire logic i_port_d_bit1,
  input wire logic i_port_d_bit2,
  input wire logic i_port_d_bit3,
  // General port pins
  input wire logic [7:0] i_port_a_pins,
  output logic [7:0] o_port_a_pins,
  output logic [7:0] o_port_a_pins_oe,
  input wire logic [7:0] i_port_b_pins,
  output logic [7:0] o_port_b_pins,
  output logic [7:0] o_port_b_pins_oe,
  input wire logic [7:0] i_port_c_pins,
  output logic [7:0] o_port_c_pins,
  output logic [7:0] o_port_c_pins_oe,
  input wire logic i_port_e_bit0,
  output logic o_port_e_bit0,
  output logic o_port_e_bit0_oe,
  // Internal sources for pin drive
  input wire logic [23:0] i_host_port_out,
  input wire logic [23:0] i_host_port_dir,
  input wire logic [15:0] i_logic_port_out,
  input wire logic [7:0] i_external_chip_selects,
  input wire logic i_host_pe0_out,
  input wire logic i_host_pe0_dir,
  // Read path and power state
  input wire logic [15:0] i_read_data,
  input wire logic i_block_selected,
  input wire logic i_power_down,
  // Toward logic arrays and memories
  output logic [15:0] o_pla_addr,
  output logic [2:0] o_pla_ctl,
  output logic [3:0] o_pla_port_d,
  output logic [23:0] o_pla_port_in,
  output logic o_test_mode_sel,
  output logic o_read_active,
  output logic o_write_low,
  output logic o_write_high,
  output logic o_mem_enable,
  output logic o_power_down_exit,
  output logic o_macrocell_clk_en,
  output logic o_array_reset,
  output logic o_flash_abort
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [mcu_pins_pkg::SYNC_W-1:0] sync1;
    logic [mcu_pins_pkg::SYNC_W-1:0] sync2;
    logic [3:0] pd_prev;
    logic [mcu_pins_pkg::BUS_W-1:0] addr;
    logic [mcu_pins_pkg::BUS_W-1:0] rdata;
    logic ad_oe;
    logic [mcu_pins_pkg::GP_W-1:0] gp_out;
    logic [mcu_pins_pkg::GP_W-1:0] gp_oe;
    logic pe0_out;
    logic pe0_oe;
    logic clk_en;
    logic pd_exit;
    logic rst_hold;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  // Pin drive per mode: returns {oe, value}
  function automatic logic [1:0] pin_drive(input logic [1:0] mode, input logic host_out,
                                           input logic host_dir, input logic logic_out);
    pin_drive = 2'h0;
    case (mcu_pins_pkg::pin_mode_type'(mode))
      mcu_pins_pkg::PIN_HOST_IO: pin_drive = {host_dir, host_out};
      mcu_pins_pkg::PIN_LOGIC_OUT: pin_drive = {1'b1, logic_out};
      default: pin_drive = 2'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronised pin views

  logic [15:0] adio;
  logic [2:0] ctl;
  logic [3:0] pd;
  logic [23:0] gp;
  logic pe0_in;
  logic rise_as;
  logic capture;
  logic [47:0] gp_mode;
  logic [23:0] gp_src;

  assign adio = st_r.sync2[mcu_pins_pkg::S_ADIO +: mcu_pins_pkg::BUS_W];
  assign ctl = st_r.sync2[mcu_pins_pkg::S_CTL +: 3];
  assign pd = st_r.sync2[mcu_pins_pkg::S_PD +: 4];
  assign gp = st_r.sync2[mcu_pins_pkg::S_GP +: mcu_pins_pkg::GP_W];
  assign pe0_in = st_r.sync2[mcu_pins_pkg::S_PE0];
  assign gp_mode = {i_port_c_mode, i_port_b_mode, i_port_a_mode};
  assign gp_src = {i_external_chip_selects, i_logic_port_out};
  assign rise_as = pd[0] & ~st_r.pd_prev[0];

  // Address capture: latch enable is transparent while high, strobe takes its rising edge
  always_comb begin
    capture = 1'b1;
    if (i_bus_muxed) begin
      case (i_pd0_mode)
        mcu_pins_pkg::PD0_LATCH_ENABLE: capture = pd[0]; // R4 R14
        mcu_pins_pkg::PD0_ADDR_STROBE: capture = rise_as; // R4 R14
        default: capture = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strobe decode

  logic low_en;
  logic high_en;
  logic data_ph;
  logic rd_act;
  logic wr_act;
  logic wr_low_only;
  logic a0;

  assign a0 = st_r.addr[mcu_pins_pkg::LANE_ADDR_BIT];

  // Lane enables and read/write strobes from the three control inputs
  always_comb begin
    low_en = 1'b1;
    high_en = 1'b1;
    data_ph = 1'b1;
    rd_act = 1'b0;
    wr_act = 1'b0;
    wr_low_only = 1'b0;
    case (i_ctl2_mode)
      mcu_pins_pkg::C2_CODE_FETCH_N: rd_act = ~ctl[2]; // R9
      mcu_pins_pkg::C2_UPPER_ENABLE_N: begin
        high_en = ~ctl[2]; // R9
        low_en = ~a0;
      end
      mcu_pins_pkg::C2_HIGH_STROBE_N: high_en = ~ctl[2]; // R9
      mcu_pins_pkg::C2_SIZE_BIT: begin
        high_en = ~a0; // R9
        low_en = a0 | ~ctl[2];
      end
      default: begin
        high_en = ~a0; // R9
        low_en = ~ctl[2];
      end
    endcase
    case (i_ctl1_mode)
      mcu_pins_pkg::C1_READ_N: rd_act = rd_act | ~ctl[1]; // R8
      mcu_pins_pkg::C1_E_CLOCK: data_ph = ctl[1]; // R8
      mcu_pins_pkg::C1_DATA_STROBE_N: data_ph = ~ctl[1]; // R8
      default: begin
        low_en = ~ctl[1]; // R8
        data_ph = low_en | (i_ctl2_mode == mcu_pins_pkg::C2_HIGH_STROBE_N && high_en);
      end
    endcase
    case (i_ctl0_mode)
      mcu_pins_pkg::C0_WRITE_N: wr_act = ~ctl[0]; // R7
      mcu_pins_pkg::C0_READ_WRITE: begin
        wr_act = ~ctl[0] & data_ph; // R7
        rd_act = rd_act | (ctl[0] & data_ph);
      end
      default: begin
        wr_act = ~ctl[0]; // R7
        wr_low_only = 1'b1;
      end
    endcase
  end

  assign o_read_active = rd_act;
  assign o_write_low = wr_act & (low_en | wr_low_only);
  // High byte write from the host strobes or from port D bit 3
  assign o_write_high = (wr_act & high_en & ~wr_low_only)
    | (i_pd3_write_high_en & ~pd[3]); // R18

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = {i_port_e_bit0, i_port_c_pins, i_port_b_pins, i_port_a_pins,
      i_port_d_bit3, i_port_d_bit2, i_port_d_bit1, i_port_d_bit0, i_host_control_in_two,
      i_host_control_in_one, i_host_control_in_zero, i_upper_addr_data_port,
      i_lower_addr_data_port};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.pd_prev = pd;
    st_nxt.rst_hold = 1'b0; // R11 R13
    // Address follows the host's wiring; on a muxed bus it holds between strobes, on a plain bus it tracks the lanes every cycle
    if (capture) begin
      st_nxt.addr = adio; // R4 R22
    end
    st_nxt.rdata = i_read_data;
    st_nxt.ad_oe = rd_act & i_block_selected; // R5
    st_nxt.clk_en = i_pd1_clock_in_sel & pd[1] & ~st_r.pd_prev[1]; // R15
    st_nxt.pd_exit = i_pd2_chip_sel_en & i_power_down & ~pd[2] & st_r.pd_prev[2]; // R17
    for (int k = 0; k < mcu_pins_pkg::GP_W; k++) begin
      {st_nxt.gp_oe[k], st_nxt.gp_out[k]} = pin_drive(gp_mode[2 * k +: 2],
        i_host_port_out[k], i_host_port_dir[k], gp_src[k]); // R19 R20
    end
    case (i_pe0_mode)
      mcu_pins_pkg::PE0_HOST_IO: begin
        st_nxt.pe0_oe = i_host_pe0_dir; // R21
        st_nxt.pe0_out = i_host_pe0_out;
      end
      mcu_pins_pkg::PE0_ADDR_OUT: begin
        st_nxt.pe0_oe = 1'b1; // R21
        st_nxt.pe0_out = st_r.addr[mcu_pins_pkg::PE0_ADDR_BIT];
      end
      default: begin
        st_nxt.pe0_oe = 1'b0; // R21
        st_nxt.pe0_out = 1'b0;
      end
    endcase
  end

  // State register; reset clears all pin drive and raises the reset hold
  // Synchronisers reset to idle pin levels so no false strobe or edge follows reset
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '{sync1: mcu_pins_pkg::SYNC_IDLE, sync2: mcu_pins_pkg::SYNC_IDLE,
        pd_prev: mcu_pins_pkg::PD_IDLE, rst_hold: mcu_pins_pkg::RST_HOLD_INIT, default: '0}; // R11
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_lower_addr_data_port = st_r.rdata[0 +: mcu_pins_pkg::BYTE_W];
  assign o_upper_addr_data_port = st_r.rdata[mcu_pins_pkg::BYTE_W +: mcu_pins_pkg::BYTE_W];
  assign o_lower_addr_data_oe = st_r.ad_oe; // R5
  assign o_upper_addr_data_oe = st_r.ad_oe; // R5
  assign o_port_a_pins = st_r.gp_out[0 +: mcu_pins_pkg::PORT_W];
  assign o_port_a_pins_oe = st_r.gp_oe[0 +: mcu_pins_pkg::PORT_W];
  assign o_port_b_pins = st_r.gp_out[mcu_pins_pkg::PORT_W +: mcu_pins_pkg::PORT_W];
  assign o_port_b_pins_oe = st_r.gp_oe[mcu_pins_pkg::PORT_W +: mcu_pins_pkg::PORT_W];
  assign o_port_c_pins = st_r.gp_out[2 * mcu_pins_pkg::PORT_W +: mcu_pins_pkg::PORT_W];
  assign o_port_c_pins_oe = st_r.gp_oe[2 * mcu_pins_pkg::PORT_W +: mcu_pins_pkg::PORT_W];
  assign o_port_e_bit0 = st_r.pe0_out;
  assign o_port_e_bit0_oe = st_r.pe0_oe;
  // Array inputs: address, controls, port D and general pins
  assign o_pla_addr = st_r.addr; // R6
  assign o_pla_ctl = ctl; // R10
  assign o_pla_port_d = pd;
  assign o_pla_port_in = gp; // R19
  assign o_test_mode_sel = (i_pe0_mode == mcu_pins_pkg::PE0_TEST_SEL) & pe0_in; // R21
  assign o_mem_enable = ~i_pd2_chip_sel_en | ~pd[2]; // R16
  assign o_power_down_exit = st_r.pd_exit;
  assign o_macrocell_clk_en = st_r.clk_en;
  assign o_array_reset = st_r.rst_hold; // R11
  assign o_flash_abort = st_r.rst_hold; // R13

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_READ_DRIVE: assert property ((rd_act && i_block_selected) |=> // R5
    o_lower_addr_data_oe && o_upper_addr_data_oe
    && o_lower_addr_data_port == $past(i_read_data[7:0])) else $error("read data not driven");
  AST_NO_DRIVE: assert property (!(rd_act && i_block_selected) |=> !o_lower_addr_data_oe) // R5
    else $error("data driven without read");
  AST_AS_CAPTURE: assert property ((i_pd0_mode == mcu_pins_pkg::PD0_ADDR_STROBE // R14
    && i_bus_muxed && rise_as) |=> o_pla_addr == $past(adio)) else $error("address not captured");
  AST_ADDR_HOLD: assert property ((i_bus_muxed && !capture) |=> $stable(o_pla_addr)) // R22
    else $error("latched address moved");
  AST_RESET_ABORT: assert property (!$past(i_rst_n) |-> o_flash_abort && o_array_reset // R13
    ##1 !o_flash_abort) else $error("abort pulse wrong");
  AST_CLK_PULSE: assert property ((i_pd1_clock_in_sel && pd[1] && !st_r.pd_prev[1]) |=> // R15
    o_macrocell_clk_en ##1 !o_macrocell_clk_en) else $error("clock enable wrong");
  AST_CHIP_SEL: assert property ((i_pd2_chip_sel_en && pd[2]) |-> !o_mem_enable) // R16
    else $error("memories enabled while deselected");
  AST_PD_EXIT: assert property (o_power_down_exit |-> $past(i_power_down) && $past(!pd[2])) // R17
    else $error("power-down exit without edge");
  AST_WRITE_HIGH: assert property ((i_pd3_write_high_en && !pd[3]) |-> o_write_high) // R18
    else $error("high write missed");
  AST_READ_N: assert property ((i_ctl1_mode == mcu_pins_pkg::C1_READ_N && !ctl[1]) |-> rd_act) // R8
    else $error("read strobe missed");
  AST_DIR_WRITE: assert property ((i_ctl0_mode == mcu_pins_pkg::C0_READ_WRITE && !ctl[0] // R7
    && i_ctl1_mode == mcu_pins_pkg::C1_DATA_STROBE_N && !ctl[1]) |-> wr_act && !rd_act)
    else $error("direction write wrong");
  AST_FETCH: assert property ((i_ctl2_mode == mcu_pins_pkg::C2_CODE_FETCH_N && !ctl[2]) // R9
    |-> o_read_active) else $error("code fetch not a read");
  AST_LOGIC_OUT: assert property ((i_port_a_mode[1:0] == 2'h1) |=> // R19
    o_port_a_pins_oe[0] && o_port_a_pins[0] == $past(i_logic_port_out[0]))
    else $error("logic output not driven");
  AST_ECS_OUT: assert property ((i_port_c_mode[1:0] == 2'h1) |=> // R20
    o_port_c_pins_oe[0] && o_port_c_pins[0] == $past(i_external_chip_selects[0]))
    else $error("chip select output not driven");
  AST_PE0_ADDR: assert property ((i_pe0_mode == mcu_pins_pkg::PE0_ADDR_OUT) |=> // R21
    o_port_e_bit0_oe && o_port_e_bit0 == $past(st_r.addr[0])) else $error("address out wrong");

  COV_READ: cover property ((rd_act && i_block_selected) ##1 o_lower_addr_data_oe);
  COV_CAPTURE: cover property (i_bus_muxed && rise_as ##1 !capture [*3]);
  COV_EXIT: cover property (o_power_down_exit);
  COV_CLK: cover property (o_macrocell_clk_en ##2 o_macrocell_clk_en);

endmodule // mcu_bus_pin_interface

// [rtl/mcu_pins_pkg.sv]
// Package of modes, bit layouts and widths for the host bus pin block
package mcu_pins_pkg;
  localparam int BUS_W = 16;
  localparam int BYTE_W = 8;
  localparam int PORT_W = 8;
  localparam int GP_W = 24;
  localparam int MODE_W = 2;
  // Layout of the synchroniser vector
  localparam int S_ADIO = 0;
  localparam int S_CTL = 16;
  localparam int S_PD = 19;
  localparam int S_GP = 23;
  localparam int S_PE0 = 47;
  localparam int SYNC_W = 48;
  // Latched address bit that port E bit 0 drives in address-out mode
  localparam int PE0_ADDR_BIT = 0;
  // Byte lane select address bit
  localparam int LANE_ADDR_BIT = 0;
  localparam logic RST_HOLD_INIT = 1'h1;
  // Idle pin levels loaded into the synchronisers in reset: strobes, chip select, high write off
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 48'h000000670000;
  localparam logic [3:0] PD_IDLE = 4'hc;

  typedef enum logic [1:0] {C0_WRITE_N, C0_READ_WRITE, C0_LOW_WRITE_N} ctl0_mode_type;
  typedef enum logic [1:0] {
    C1_READ_N, C1_E_CLOCK, C1_DATA_STROBE_N, C1_LOW_STROBE_N
  } ctl1_mode_type;
  typedef enum logic [2:0] {
    C2_CODE_FETCH_N, C2_UPPER_ENABLE_N, C2_HIGH_STROBE_N, C2_SIZE_BIT, C2_LOW_STROBE_N
  } ctl2_mode_type;
  typedef enum logic [1:0] {PD0_LATCH_ENABLE, PD0_ADDR_STROBE, PD0_LOGIC_IN} pd0_mode_type;
  typedef enum logic [1:0] {PIN_HOST_IO, PIN_LOGIC_OUT, PIN_LOGIC_IN} pin_mode_type;
  typedef enum logic [1:0] {PE0_HOST_IO, PE0_ADDR_OUT, PE0_TEST_SEL} pe0_mode_type;
endpackage

// [verif/mcu_bus_pin_interface_bench.sv]
// Self-checking bench for the host bus pin block
module mcu_bus_pin_interface_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [1:0] m0; logic [1:0] m1; logic [2:0] m2; logic [2:0] c; logic [15:0] a; logic [2:0] e;
  } row_type;
  logic i_ref_clk, i_rst_n, i_bus_muxed, i_pd1_clock_in_sel, i_pd2_chip_sel_en;
  logic i_pd3_write_high_en, i_host_control_in_zero, i_host_control_in_one;
  logic i_host_control_in_two, i_port_d_bit0, i_port_d_bit1, i_port_d_bit2, i_port_d_bit3;
  logic i_port_e_bit0, o_port_e_bit0, o_port_e_bit0_oe, i_host_pe0_out, i_host_pe0_dir;
  logic i_block_selected, i_power_down, o_lower_addr_data_oe, o_upper_addr_data_oe;
  logic o_test_mode_sel, o_read_active, o_write_low, o_write_high, o_mem_enable;
  logic o_power_down_exit, o_macrocell_clk_en, o_array_reset, o_flash_abort;
  mcu_pins_pkg::ctl0_mode_type i_ctl0_mode;
  mcu_pins_pkg::ctl1_mode_type i_ctl1_mode;
  mcu_pins_pkg::ctl2_mode_type i_ctl2_mode;
  mcu_pins_pkg::pd0_mode_type i_pd0_mode;
  mcu_pins_pkg::pe0_mode_type i_pe0_mode;
  logic [15:0] i_port_a_mode, i_port_b_mode, i_port_c_mode, i_logic_port_out, i_read_data;
  logic [15:0] o_pla_addr;
  logic [7:0] i_lower_addr_data_port, o_lower_addr_data_port, i_upper_addr_data_port;
  logic [7:0] o_upper_addr_data_port, i_port_a_pins, o_port_a_pins, o_port_a_pins_oe;
  logic [7:0] i_port_b_pins, o_port_b_pins, o_port_b_pins_oe, i_port_c_pins, o_port_c_pins;
  logic [7:0] o_port_c_pins_oe, i_external_chip_selects;
  logic [23:0] i_host_port_out, i_host_port_dir, o_pla_port_in;
  logic [2:0] o_pla_ctl;
  logic [3:0] o_pla_port_d;
  int miscompares = 0;
  int checks = 0;
  int n;
  // Modes, control pins {2,1,0}, address, then expected {read, write low, write high}
  row_type rows [7] = '{'{2'h0, 2'h0, 3'h1, 3'h2, 16'h1234, 3'h3},
    '{2'h0, 2'h0, 3'h1, 3'h5, 16'hfff1, 3'h4}, '{2'h2, 2'h3, 3'h2, 3'h4, 16'h0000, 3'h2},
    '{2'h1, 2'h1, 3'h3, 3'h3, 16'ha5a4, 3'h4}, '{2'h1, 2'h2, 3'h4, 3'h0, 16'h8001, 3'h2},
    '{2'h0, 2'h0, 3'h0, 3'h3, 16'h5555, 3'h4}, '{2'h0, 2'h0, 3'h3, 3'h2, 16'h0003, 3'h2}};

  ////////////////////////////////////////////////////////////////////////////////
  // Design, host model, two-way pin levels and clock
  mcu_bus_pin_interface dut (.i_ref_clk, .i_rst_n, .i_bus_muxed, .i_ctl0_mode, .i_ctl1_mode,
    .i_ctl2_mode, .i_pd0_mode, .i_pd1_clock_in_sel, .i_pd2_chip_sel_en, .i_pd3_write_high_en,
    .i_port_a_mode, .i_port_b_mode, .i_port_c_mode, .i_pe0_mode, .i_lower_addr_data_port,
    .o_lower_addr_data_port, .o_lower_addr_data_oe, .i_upper_addr_data_port,
    .o_upper_addr_data_port, .o_upper_addr_data_oe, .i_host_control_in_zero,
    .i_host_control_in_one, .i_host_control_in_two, .i_port_d_bit0, .i_port_d_bit1,
    .i_port_d_bit2, .i_port_d_bit3, .i_port_a_pins, .o_port_a_pins, .o_port_a_pins_oe,
    .i_port_b_pins, .o_port_b_pins, .o_port_b_pins_oe, .i_port_c_pins, .o_port_c_pins,
    .o_port_c_pins_oe, .i_port_e_bit0, .o_port_e_bit0, .o_port_e_bit0_oe, .i_host_port_out,
    .i_host_port_dir, .i_logic_port_out, .i_external_chip_selects, .i_host_pe0_out,
    .i_host_pe0_dir, .i_read_data, .i_block_selected, .i_power_down, .o_pla_addr, .o_pla_ctl,
    .o_pla_port_d, .o_pla_port_in, .o_test_mode_sel, .o_read_active, .o_write_low,
    .o_write_high, .o_mem_enable, .o_power_down_exit, .o_macrocell_clk_en, .o_array_reset,
    .o_flash_abort);
  mcu_host_model host (.i_ref_clk, .i_dev_lower(o_lower_addr_data_port),
    .i_dev_lower_oe(o_lower_addr_data_oe), .i_dev_upper(o_upper_addr_data_port),
    .i_dev_upper_oe(o_upper_addr_data_oe), .o_lower_wire(i_lower_addr_data_port),
    .o_upper_wire(i_upper_addr_data_port), .o_latch(i_port_d_bit0),
    .o_ctl({i_host_control_in_two, i_host_control_in_one, i_host_control_in_zero}));
  assign i_port_a_pins = (o_port_a_pins & o_port_a_pins_oe) | (8'h96 & ~o_port_a_pins_oe);
  assign i_port_b_pins = (o_port_b_pins & o_port_b_pins_oe) | (8'h4b & ~o_port_b_pins_oe);
  assign i_port_c_pins = (o_port_c_pins & o_port_c_pins_oe) | (8'hd2 & ~o_port_c_pins_oe);
  assign i_port_e_bit0 = o_port_e_bit0_oe ? o_port_e_bit0 : 1'b1;
  always #12.5 i_ref_clk = ~i_ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, wait, pulse count and verdict
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge i_ref_clk);
  endtask
  task automatic count(input logic sel, output int c);
    c = 0;
    repeat (8) begin
      @(negedge i_ref_clk);
      if ((sel ? o_power_down_exit : o_macrocell_clk_en) === 1'b1) c++;
    end
  endtask
  task automatic test_done();
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_oe();
    int k;
    for (k = 0; k < 8 && o_lower_addr_data_oe !== 1'b1; k++) @(negedge i_ref_clk);
    if (k == 8) begin
      miscompares++;
      test_done();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    i_ref_clk = 1'b0;
    i_rst_n = 1'b0;
    i_bus_muxed = 1'b0;
    i_ctl0_mode = mcu_pins_pkg::C0_WRITE_N;
    i_ctl1_mode = mcu_pins_pkg::C1_READ_N;
    i_ctl2_mode = mcu_pins_pkg::C2_UPPER_ENABLE_N;
    i_pd0_mode = mcu_pins_pkg::PD0_LATCH_ENABLE;
    i_pe0_mode = mcu_pins_pkg::PE0_HOST_IO;
    {i_pd1_clock_in_sel, i_pd2_chip_sel_en, i_pd3_write_high_en} = 3'h0;
    {i_port_d_bit1, i_port_d_bit2, i_port_d_bit3} = 3'h3;
    {i_port_a_mode, i_port_b_mode, i_port_c_mode} = 48'h0;
    {i_host_port_out, i_host_port_dir} = 48'h3c5aa5ffffff;
    {i_logic_port_out, i_external_chip_selects} = 24'h69c3e1;
    {i_host_pe0_out, i_host_pe0_dir, i_block_selected, i_power_down} = 4'h0;
    i_read_data = 16'h0000;
    cyc(4);
    chk("array_reset", o_array_reset, 24'h1);
    chk("flash_abort", o_flash_abort, 24'h1);
    chk("port_a_oe", o_port_a_pins_oe, 24'h0);
    i_rst_n = 1'b1;
    cyc(2);
    chk("array_reset", o_array_reset, 24'h0);
    // Strobe conventions and address flow on a plain bus
    foreach (rows[i]) begin
      i_ctl0_mode = mcu_pins_pkg::ctl0_mode_type'(rows[i].m0);
      i_ctl1_mode = mcu_pins_pkg::ctl1_mode_type'(rows[i].m1);
      i_ctl2_mode = mcu_pins_pkg::ctl2_mode_type'(rows[i].m2);
      host.strobes(rows[i].c);
      host.put({4'h0, rows[i].a}, 1'b0);
      cyc(5);
      chk("pla_addr", o_pla_addr, rows[i].a);
      chk("pla_ctl", o_pla_ctl, rows[i].c);
      chk("read_active", o_read_active, rows[i].e[2]);
      chk("write_low", o_write_low, rows[i].e[1]);
      chk("write_high", o_write_high, rows[i].e[0]);
      chk("addr_oe", o_lower_addr_data_oe, 24'h0);
    end
    // Multiplexed capture, latch form then strobe form with burst lanes, then no capture
    i_ctl0_mode = mcu_pins_pkg::C0_WRITE_N;
    i_ctl1_mode = mcu_pins_pkg::C1_READ_N;
    host.strobes(3'h7);
    i_bus_muxed = 1'b1;
    i_pe0_mode = mcu_pins_pkg::PE0_ADDR_OUT;
    host.addr_phase(20'h0c3a5, 1'b0);
    host.put(20'h00ff0, 1'b0);
    cyc(5);
    chk("pla_addr", o_pla_addr, 24'hc3a5);
    chk("pe0", {o_port_e_bit0_oe, o_port_e_bit0}, 24'h3);
    i_pd0_mode = mcu_pins_pkg::PD0_ADDR_STROBE;
    host.addr_phase(20'habcd3, 1'b1);
    chk("pla_addr", o_pla_addr, 24'habcd);
    i_pd0_mode = mcu_pins_pkg::PD0_LOGIC_IN;
    host.addr_phase(20'h01111, 1'b0);
    chk("pla_addr", o_pla_addr, 24'habcd);
    // Read drive, reset in mid-read, then no drive without strobe or selection
    host.release_bus();
    i_read_data = 16'hbeef;
    i_block_selected = 1'b1;
    host.strobes(3'h5);
    wait_oe();
    cyc(1);
    chk("read_data", {o_upper_addr_data_port, o_lower_addr_data_port}, 24'hbeef);
    chk("lanes", {i_upper_addr_data_port, i_lower_addr_data_port}, 24'hbeef);
    i_rst_n = 1'b0;
    cyc(1);
    chk("addr_oe", o_lower_addr_data_oe, 24'h0);
    chk("flash_abort", o_flash_abort, 24'h1);
    i_rst_n = 1'b1;
    cyc(2);
    chk("flash_abort", o_flash_abort, 24'h0);
    host.strobes(3'h7);
    cyc(4);
    chk("addr_oe", o_upper_addr_data_oe, 24'h0);
    i_block_selected = 1'b0;
    host.strobes(3'h5);
    cyc(5);
    chk("addr_oe", o_lower_addr_data_oe, 24'h0);
    host.strobes(3'h7);
    // High byte write strobe on port D bit 3
    i_pd3_write_high_en = 1'b1;
    i_port_d_bit3 = 1'b0;
    cyc(5);
    chk("write_lanes", {o_write_high, o_write_low}, 24'h2);
    i_port_d_bit3 = 1'b1;
    cyc(5);
    chk("write_high", o_write_high, 24'h0);
    // Macrocell clock input, chip select and power-down exit
    i_pd1_clock_in_sel = 1'b1;
    i_port_d_bit1 = 1'b1;
    count(1'b0, n);
    chk("clk_en_pulses", 24'(n), 24'h1);
    i_pd2_chip_sel_en = 1'b1;
    cyc(5);
    chk("mem_enable", o_mem_enable, 24'h0);
    i_power_down = 1'b1;
    i_port_d_bit2 = 1'b0;
    count(1'b1, n);
    chk("exit_pulses", 24'(n), 24'h1);
    chk("mem_enable", o_mem_enable, 24'h1);
    // Port pin functions: host output, logic output, logic input
    for (int m = 0; m < 3; m++) begin
      i_port_a_mode = {8{m[1:0]}};
      i_port_b_mode = {8{m[1:0]}};
      i_port_c_mode = {8{m[1:0]}};
      cyc(4);
      chk("pa_oe", o_port_a_pins_oe, (m == 2) ? 24'h0 : 24'hff);
      chk("pb_oe", o_port_b_pins_oe, (m == 2) ? 24'h0 : 24'hff);
      chk("pc_oe", o_port_c_pins_oe, (m == 2) ? 24'h0 : 24'hff);
      if (m == 0) chk("pb", o_port_b_pins, i_host_port_out[15:8]);
      if (m == 0) chk("pa", o_port_a_pins, i_host_port_out[7:0]);
      if (m == 1) chk("pa", o_port_a_pins, i_logic_port_out[7:0]);
      if (m == 1) chk("pc", o_port_c_pins, i_external_chip_selects);
      if (m == 2) chk("port_in", o_pla_port_in, 24'hd24b96);
    end
    // Port E bit 0 as test mode select input, port D pins toward the arrays
    i_pe0_mode = mcu_pins_pkg::PE0_TEST_SEL;
    cyc(4);
    chk("test_sel", {o_port_e_bit0_oe, o_test_mode_sel}, 24'h1);
    chk("port_d", o_pla_port_d, 24'ha);
    test_done();
  end
endmodule // mcu_bus_pin_interface_bench

// [verif/mcu_host_model.sv]
// Host microcontroller model: address/data lanes, bus strobes and latch strobe
module mcu_host_model (
  // Clock
  input wire logic i_ref_clk,
  // Device drive of the address/data pins
  input wire logic [7:0] i_dev_lower,
  input wire logic i_dev_lower_oe,
  input wire logic [7:0] i_dev_upper,
  input wire logic i_dev_upper_oe,
  // Resolved pins and strobes
  output logic [7:0] o_lower_wire,
  output logic [7:0] o_upper_wire,
  output logic [2:0] o_ctl,
  output logic o_latch
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] lanes_r = 16'h0000;
  logic drive_r = 1'b0;
  logic [15:0] last_r = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Idle bus strobes high, latch strobe low
  initial begin
    o_ctl = 3'h7;
    o_latch = 1'b0;
  end

  // Device drive wins; released lanes move every cycle, never hold the last value
  assign o_lower_wire = i_dev_lower_oe ? i_dev_lower : (drive_r ? lanes_r[7:0] : ~last_r[7:0]);
  assign o_upper_wire = i_dev_upper_oe ? i_dev_upper : (drive_r ? lanes_r[15:8] : ~last_r[15:8]);
  always @(posedge i_ref_clk) begin
    last_r <= {o_upper_wire, o_lower_wire};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Put address or data on the lanes; burst hosts shift by four bits
  task automatic put(input logic [19:0] a, input logic burst);
    @(negedge i_ref_clk);
    lanes_r = burst ? a[19:4] : a[15:0];
    drive_r = 1'b1;
  endtask

  // Address phase: lanes settle, latch pulses, lanes held past its fall
  task automatic addr_phase(input logic [19:0] a, input logic burst);
    put(a, burst);
    repeat (3) @(negedge i_ref_clk);
    o_latch = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    o_latch = 1'b0;
    repeat (3) @(negedge i_ref_clk);
  endtask

  // Let go of the lanes
  task automatic release_bus();
    @(negedge i_ref_clk);
    drive_r = 1'b0;
  endtask

  // Control pins in the convention the device is set to
  task automatic strobes(input logic [2:0] c);
    @(negedge i_ref_clk);
    o_ctl = c;
  endtask
endmodule // mcu_host_model
